// ===== core/mcb_master.v
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mcb_regs.vh"

module mcb_master (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    output wire sck_o,
    output wire mosi_o,
    input wire miso_i,
    output wire irq_o
);

localparam ST_IDLE = 4'h0;
localparam ST_RS_A = 4'h1;
localparam ST_RS_B = 4'h2;
localparam ST_RS_C = 4'h3;
localparam ST_RS_D = 4'h4;
localparam ST_RS_E = 4'h5;
localparam ST_P_A = 4'h6;
localparam ST_P_B = 4'h7;
localparam ST_P_C = 4'h8;
localparam ST_P_D = 4'h9;
localparam ST_TX = 4'ha;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [1:0] sda_sy_r;
reg [1:0] scl_sy_r;
reg [1:0] miso_sy_r;
wire sda_s = sda_sy_r[1];
wire scl_s = scl_sy_r[1];

always @(posedge clk_i) begin
    if (rst_i) begin
        sda_sy_r <= 2'h3;
        scl_sy_r <= 2'h3;
        miso_sy_r <= 2'h0;
    end else begin
        sda_sy_r <= {sda_sy_r[0], sda_i};
        scl_sy_r <= {scl_sy_r[0], scl_i};
        miso_sy_r <= {miso_sy_r[0], miso_i};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers and state
reg [7:0] reload_r;
reg [7:0] txbuf_r;
reg [7:0] rxbuf_r;
reg rsen_r;
reg pen_r;
reg spi_r;
reg bf_r;
reg stop_r;
reg ack_rx_r;
reg [1:0] irq_st_r;
reg [1:0] irq_mask_r;
reg [3:0] state_r;
reg [7:0] brg_r;
reg pre_r;
reg run_r;
reg sda_drv_r;
reg scl_drv_r;
reg sck_r;
reg [3:0] nbit_r;
reg half_r;

// Writes land on the edge at which the master samples ack high
wire wb_req = wb_cyc_i & wb_stb_i & wb_ack_o;
wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
wire [3:0] wb_idx = wb_adr_i[5:2];
wire wr_reload = wb_wr & (wb_idx == `MCB_ADR_RELOAD);
wire wr_tx = wb_wr & (wb_idx == `MCB_ADR_TXBUF);
wire wr_ctrl = wb_wr & (wb_idx == `MCB_ADR_CTRL);
wire wr_irq = wb_wr & (wb_idx == `MCB_ADR_IRQ);
wire wr_mask = wb_wr & (wb_idx == `MCB_ADR_MASK);
wire idle = (state_r == ST_IDLE);

// One baud counter step every second oscillator cycle, so a rollover lasts
// 2*(reload+1) cycles and two rollovers make one serial clock period.
wire expire = run_r & pre_r & (brg_r == 8'h00);

// Events decided by the sequencer
reg col;
reg done;
reg load;
reg stop_ev;

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave: one wait state, unmapped words read zero
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        case (wb_idx)
            `MCB_ADR_RELOAD: wb_dat_o <= {24'h000000, reload_r};
            `MCB_ADR_TXBUF: wb_dat_o <= {24'h000000, rxbuf_r};
            `MCB_ADR_CTRL: wb_dat_o <= {29'h00000000, spi_r, pen_r, rsen_r};
            `MCB_ADR_STAT: wb_dat_o <= {24'h000000, 1'b0, ack_rx_r, 1'b0, stop_r,
                                        1'b0, ~idle, 1'b0, bf_r};
            `MCB_ADR_IRQ: wb_dat_o <= {30'h00000000, irq_st_r};
            `MCB_ADR_MASK: wb_dat_o <= {30'h00000000, irq_mask_r};
            default: wb_dat_o <= 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Software registers and interrupts
always @(posedge clk_i) begin
    if (rst_i) begin
        reload_r <= `MCB_RELOAD_RST;
        spi_r <= 1'b0;
        irq_st_r <= 2'h0;
        irq_mask_r <= 2'h0;
    end else begin
        // Values below 3 break I2C timing; software must avoid them
        if (wr_reload) begin
            reload_r <= wb_dat_i[7:0];
        end
        if (wr_ctrl & idle) begin
            spi_r <= wb_dat_i[`MCB_CTRL_SPI];
        end
        if (wr_mask) begin
            irq_mask_r <= wb_dat_i[1:0];
        end
        // Hardware set wins over a write-one clear in the same cycle
        irq_st_r <= (irq_st_r & ~(wr_irq ? wb_dat_i[1:0] : 2'h0)) | {done, col};
    end
end

assign irq_o = |(irq_st_r & irq_mask_r);

////////////////////////////////////////////////////////////////////////////////
// Baud counter shared by both modes
always @(posedge clk_i) begin
    if (rst_i) begin
        brg_r <= 8'h00;
        pre_r <= 1'b0;
        run_r <= 1'b0;
    end else if (load | (run_r & expire & ~done & ~col)) begin
        brg_r <= reload_r;
        pre_r <= 1'b0;
        run_r <= 1'b1;
    end else if (done | col) begin
        run_r <= 1'b0;
    end else if (run_r) begin
        pre_r <= ~pre_r;
        if (pre_r) begin
            brg_r <= brg_r - 8'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Condition and transfer sequencer
reg [3:0] state_nxt;

always @* begin
    state_nxt = state_r;
    col = 1'b0;
    done = 1'b0;
    load = 1'b0;
    stop_ev = 1'b0;
    case (state_r)
        ST_IDLE: begin
            if (wr_tx) begin
                state_nxt = ST_TX;
                load = 1'b1;
            end else if (wr_ctrl & ~spi_r & wb_dat_i[`MCB_CTRL_RSEN]) begin
                state_nxt = ST_RS_A;
            end else if (wr_ctrl & ~spi_r & wb_dat_i[`MCB_CTRL_PEN]) begin
                state_nxt = ST_P_A;
            end
        end
        ST_RS_A: begin
            if (sda_s) begin
                load = 1'b1;
                state_nxt = ST_RS_B;
            end
        end
        ST_RS_B: begin
            if (expire) begin
                state_nxt = ST_RS_C;
            end
        end
        ST_RS_C: begin
            if (scl_s) begin
                if (~sda_s) begin
                    col = 1'b1;
                end else begin
                    load = 1'b1;
                    state_nxt = ST_RS_D;
                end
            end
        end
        ST_RS_D: begin
            // An early SDA fall is another master's Start and is tolerated
            if (~scl_s & ~sda_drv_r) begin
                col = 1'b1;
            end else if (expire) begin
                load = 1'b1;
                state_nxt = ST_RS_E;
            end
        end
        ST_RS_E: begin
            if (expire) begin
                done = 1'b1;
            end
        end
        ST_P_A: begin
            if (~sda_s) begin
                state_nxt = ST_P_B;
            end
        end
        ST_P_B: begin
            if (scl_s) begin
                load = 1'b1;
                state_nxt = ST_P_C;
            end
        end
        ST_P_C: begin
            if (~scl_s) begin
                col = 1'b1;
            end else if (expire) begin
                load = 1'b1;
                state_nxt = ST_P_D;
            end
        end
        ST_P_D: begin
            if (~scl_s & ~sda_s) begin
                col = 1'b1;
            end else if (expire) begin
                if (~sda_s) begin
                    col = 1'b1;
                end else begin
                    stop_ev = 1'b1;
                    done = 1'b1;
                end
            end
        end
        ST_TX: begin
            if (expire & half_r & (nbit_r == 4'h1)) begin
                done = 1'b1;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
    if (col | done) begin
        state_nxt = ST_IDLE;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        state_r <= ST_IDLE;
        rsen_r <= 1'b0;
        pen_r <= 1'b0;
        sda_drv_r <= 1'b0;
        scl_drv_r <= 1'b0;
        sck_r <= 1'b0;
        txbuf_r <= 8'h00;
        rxbuf_r <= 8'h00;
        bf_r <= 1'b0;
        stop_r <= 1'b0;
        ack_rx_r <= 1'b0;
        nbit_r <= 4'h0;
        half_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        if (state_r == ST_IDLE) begin
            if (wr_tx) begin
                txbuf_r <= wb_dat_i[7:0];
                bf_r <= 1'b1;
                half_r <= 1'b0;
                nbit_r <= spi_r ? `MCB_SPI_BITS : `MCB_I2C_BITS;
                sda_drv_r <= ~spi_r & ~wb_dat_i[7];
                scl_drv_r <= ~spi_r;
            end else if (wr_ctrl & ~spi_r) begin
                rsen_r <= wb_dat_i[`MCB_CTRL_RSEN];
                pen_r <= wb_dat_i[`MCB_CTRL_PEN] & ~wb_dat_i[`MCB_CTRL_RSEN];
                if (wb_dat_i[`MCB_CTRL_RSEN]) begin
                    sda_drv_r <= 1'b0;
                end else if (wb_dat_i[`MCB_CTRL_PEN]) begin
                    sda_drv_r <= 1'b1;
                    stop_r <= 1'b0;
                end
            end
        end
        if ((state_r == ST_RS_B) & expire) begin
            scl_drv_r <= 1'b0;
        end
        if ((state_r == ST_RS_D) & expire & scl_s) begin
            sda_drv_r <= 1'b1;
        end
        if ((state_r == ST_RS_E) & expire) begin
            scl_drv_r <= 1'b1;
        end
        if ((state_r == ST_P_A) & ~sda_s) begin
            scl_drv_r <= 1'b0;
        end
        if ((state_r == ST_P_C) & scl_s & expire) begin
            sda_drv_r <= 1'b0;
        end
        if (stop_ev) begin
            stop_r <= 1'b1;
        end
        if ((state_r == ST_TX) & expire) begin
            half_r <= ~half_r;
            if (~half_r) begin
                // Rising clock edge: release SCL or raise SCK, sample input
                scl_drv_r <= 1'b0;
                sck_r <= spi_r;
                if (spi_r) begin
                    rxbuf_r <= {rxbuf_r[6:0], miso_sy_r[1]};
                end else if (nbit_r == 4'h1) begin
                    ack_rx_r <= sda_s;
                end
            end else begin
                // Falling edge: drive the clock low, present the next bit
                scl_drv_r <= ~spi_r;
                sck_r <= 1'b0;
                nbit_r <= nbit_r - 4'h1;
                txbuf_r <= {txbuf_r[6:0], 1'b0};
                sda_drv_r <= ~spi_r & (nbit_r > 4'h2) & ~txbuf_r[6];
            end
        end
        if (done & (state_r == ST_TX)) begin
            bf_r <= 1'b0;
        end
        if (done | col) begin
            rsen_r <= 1'b0;
            pen_r <= 1'b0;
        end
        if (col) begin
            sda_drv_r <= 1'b0;
            scl_drv_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pins: open drain lines only ever pull low
assign sda_o = 1'b0;
assign scl_o = 1'b0;
assign sda_oe_o = sda_drv_r;
assign scl_oe_o = scl_drv_r;
assign sck_o = sck_r;
assign mosi_o = txbuf_r[7];

endmodule // mcb_master
`default_nettype wire

// ===== pkg/mcb_regs.vh
`ifndef MCB_REGS_VH
`define MCB_REGS_VH
// Word indices of the registers, decoded from byte address bits 5:2
`define MCB_ADR_RELOAD 4'h0
`define MCB_ADR_TXBUF 4'h1
`define MCB_ADR_CTRL 4'h2
`define MCB_ADR_STAT 4'h3
`define MCB_ADR_IRQ 4'h4
`define MCB_ADR_MASK 4'h5
// Control fields
`define MCB_CTRL_RSEN 0
`define MCB_CTRL_PEN 1
`define MCB_CTRL_SPI 2
// Status fields
`define MCB_STAT_BF 0
`define MCB_STAT_BUSY 2
`define MCB_STAT_STOP 4
`define MCB_STAT_ACK 6
// Interrupt fields
`define MCB_IRQ_BCOL 0
`define MCB_IRQ_DONE 1
// Reset values
`define MCB_RELOAD_RST 8'h4f
`define MCB_STAT_RST 8'h00
// Bits per transfer
`define MCB_I2C_BITS 4'h9
`define MCB_SPI_BITS 4'h8
`endif

// ===== test/mcb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_bus_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic sda_oe_i,
    input wire logic scl_oe_i,
    input wire logic mosi_i,
    output logic sda_o,
    output logic scl_o,
    output logic miso_o
);
    logic [3:0] hi_cnt_r;
    logic scl_pull_r;
    // Pull-ups: a released line reads high
    assign scl_o = !(scl_oe_i || scl_pull_r);
    // Mode 1: another master sends a zero while SCL is high
    assign sda_o = !(sda_oe_i || (mode_i == 2'h1 && scl_o));
    assign miso_o = mosi_i;
    // Mode 2: another master pulls SCL low early in the high phase
    always @(posedge clk_i) begin
        if (rst_i || mode_i != 2'h2) begin
            hi_cnt_r <= 4'h0;
            scl_pull_r <= 1'b0;
        end else if (scl_o) begin
            hi_cnt_r <= hi_cnt_r + 4'h1;
            scl_pull_r <= (hi_cnt_r == 4'h5);
        end
    end
endmodule // mcb_bus_model
`default_nettype wire

// ===== test/mcb_master_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcb_regs.vh"
module mcb_master_properties (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire sda_o,
    input wire scl_o,
    input wire scl_oe_o,
    input wire sck_o,
    input wire mosi_o,
    input wire irq_o
);
    logic [7:0] reload_r;
    logic scl_q_r;
    logic sck_q_r;
    logic [15:0] scl_cnt_r;
    logic [15:0] sck_cnt_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // Mirror of the reload value so the spacing bounds follow software
    always @(posedge clk_i) begin
        if (rst_i) begin
            reload_r <= `MCB_RELOAD_RST;
            scl_cnt_r <= 16'hffff;
            sck_cnt_r <= 16'hffff;
        end else begin
            if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[5:2] == `MCB_ADR_RELOAD) begin
                reload_r <= wb_dat_i[7:0];
            end
            scl_cnt_r <= (scl_oe_o != scl_q_r) ? 16'h0000 : scl_cnt_r + {15'h0000, scl_cnt_r != 16'hffff};
            sck_cnt_r <= (sck_o != sck_q_r) ? 16'h0000 : sck_cnt_r + {15'h0000, sck_cnt_r != 16'hffff};
        end
        scl_q_r <= scl_oe_o;
        sck_q_r <= sck_o;
    end
    ////////////////////////////////////////////////////////////////
    AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_WB_NOREQ: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack after idle bus");
    AST_OPEN_DRAIN: assert property (!sda_o && !scl_o)
        else $error("line driven high");
    AST_SCL_PERIOD: assert property ($rose(scl_oe_o) |-> scl_cnt_r >= {7'h00, reload_r, 1'b0})
        else $error("scl high phase too short");
    AST_SCK_PERIOD: assert property ($changed(sck_o) |-> sck_cnt_r >= {7'h00, reload_r, 1'b0})
        else $error("sck half period too short");
    AST_MOSI_EDGE: assert property ($changed(mosi_o) |-> !sck_o)
        else $error("mosi moved while sck high");
    COV_IRQ: cover property ($rose(irq_o));
    COV_SCK: cover property ($rose(sck_o));
    COV_SCL: cover property ($fell(scl_oe_o));
endmodule // mcb_master_properties
`default_nettype wire

// ===== test/mcb_master_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcb_regs.vh"
module mcb_master_tb_top;
    localparam logic [5:0] A_REL = {`MCB_ADR_RELOAD, 2'b00};
    localparam logic [5:0] A_TX = {`MCB_ADR_TXBUF, 2'b00};
    localparam logic [5:0] A_CTL = {`MCB_ADR_CTRL, 2'b00};
    localparam logic [5:0] A_ST = {`MCB_ADR_STAT, 2'b00};
    localparam logic [5:0] A_IRQ = {`MCB_ADR_IRQ, 2'b00};
    localparam logic [5:0] A_MSK = {`MCB_ADR_MASK, 2'b00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack, sda_oe, scl_oe, sck, mosi, irq;
    wire sda_line, scl_line, miso;
    logic [1:0] pmode = 2'h0;
    logic [31:0] seed = 32'h22;
    logic [31:0] r;
    logic [31:0] expq [$];
    int miscompares = 0;
    int checks_done = 0;
    time t0;
    always #5 clk_i = ~clk_i;
    mcb_master i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sda_i(sda_line), .sda_o(),
        .sda_oe_o(sda_oe), .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sck_o(sck), .mosi_o(mosi),
        .miso_i(miso), .irq_o(irq));
    mcb_bus_model i_far (.clk_i(clk_i), .rst_i(rst_i), .mode_i(pmode), .sda_oe_i(sda_oe), .scl_oe_i(scl_oe),
        .mosi_i(mosi), .sda_o(sda_line), .scl_o(scl_line), .miso_o(miso));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // Only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
    endtask
    // Byte transfer first, so the condition starts with SCL held low
    task automatic cond(input logic [1:0] m, input logic [31:0] ctl, input logic [31:0] ev, input logic sx, input logic cx);
        r = xs();
        wb(1'b1, A_TX, {24'h0, r[7:0]});
        wait_irq();
        wb(1'b1, A_IRQ, 32'h3);
        pmode <= m;
        wb(1'b1, A_CTL, ctl);
        wait_irq();
        pmode <= 2'h0;
        rd(A_IRQ, ev);
        chk({31'h0, sda_oe}, {31'h0, sx});
        chk({31'h0, scl_oe}, {31'h0, cx});
        rd(A_CTL, 32'h0);
        wb(1'b1, A_IRQ, 32'h3);
    endtask
    task test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we && expq.size() > 0) chk(rdat, expq.pop_front());
    end
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_REL, {24'h0, `MCB_RELOAD_RST});
        rd(A_ST, {24'h0, `MCB_STAT_RST});
        wb(1'b1, 6'h18, 32'hff);
        rd(6'h18, 32'h0);
        r = 32'h3 + xs() % 32'hfd;
        wb(1'b1, A_REL, r);
        rd(A_REL, r);
        wb(1'b1, A_REL, 32'h4);
        wb(1'b1, A_MSK, 32'h3);
        wb(1'b1, A_CTL, 32'h4);
        r = xs();
        wb(1'b1, A_TX, {24'h0, r[7:0]});
        @(posedge sck);
        t0 = $time;
        @(posedge sck);
        chk(32'(($time - t0) / 10), 32'h14);
        wait_irq();
        rd(A_TX, {24'h0, r[7:0]});
        rd(A_IRQ, 32'h2);
        wb(1'b1, A_MSK, 32'h0);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, A_MSK, 32'h3);
        wb(1'b1, A_IRQ, 32'h3);
        @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        repeat (40) @(posedge clk_i);
        chk({31'h0, sck}, 32'h0);
        wb(1'b1, A_CTL, 32'h0);
        cond(2'h0, 32'h1, 32'h2, 1'b1, 1'b1);
        cond(2'h1, 32'h1, 32'h1, 1'b0, 1'b0);
        cond(2'h2, 32'h1, 32'h1, 1'b0, 1'b0);
        cond(2'h0, 32'h2, 32'h2, 1'b0, 1'b0);
        rd(A_ST, 32'h50);
        cond(2'h1, 32'h2, 32'h1, 1'b0, 1'b0);
        cond(2'h2, 32'h2, 32'h1, 1'b0, 1'b0);
        test_done;
    end
endmodule // mcb_master_tb_top
bind mcb_master mcb_master_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .sda_o(sda_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sck_o(sck_o), .mosi_o(mosi_o),
    .irq_o(irq_o));
`default_nettype wire
